// >>> hdl/msd_map.svh
// Functional notes
// - Result pair holds last test outcome
// - Self test pass gives 0x1B, 0xBF
// - Good firmware CRC gives 0xBE, 0xEF
// - Self test wipes firmware and settings
// - Auto mode reviews exposure each frame
// - Exposure steps by one sixteenth
// - Exposure clamped to maximum bound at each frame, not at reset or restore
// - Frame period shown as cycle count
// - Motion clear write zeroes displacement
// - Key 0x83 captures 1536 pixels
// - Capture write halts navigation until reset
// - Each capture read once capture ready returns pixel, advances
// - Single and burst reads share pointer
// - Reads before capture ready return zero
// - Capture register keeps no written value
// - Download accepted only with unlock 0x18
// - CRC test suspends navigation
// - Gain disable holds exposure at bound
// - Fixed rate uses maximum period bound
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH

// Register offsets
`define MSD_OFS_RESULT_LO   7'h0C
`define MSD_OFS_RESULT_HI   7'h0D
`define MSD_OFS_EXPOSE_LO   7'h0E
`define MSD_OFS_EXPOSE_HI   7'h0F
`define MSD_OFS_PERIOD_LO   7'h10
`define MSD_OFS_PERIOD_HI   7'h11
`define MSD_OFS_MCLEAR      7'h12
`define MSD_OFS_PIXEL       7'h13
`define MSD_OFS_UNLOCK      7'h14

// Command and result values
`define MSD_CAPTURE_KEY     8'h83
`define MSD_UNLOCK_LOAD     8'h18
`define MSD_UNLOCK_CRC      8'hA1
`define MSD_SELFTEST_PASS   16'h1BBF
`define MSD_SELFTEST_FAIL   16'h0000
`define MSD_CRC_PASS        16'hBEEF
`define MSD_CRC_POLY        16'h1021
`define MSD_CRC_INIT        16'hFFFF

// Reset values
`define MSD_EXPOSE_RST      16'h0085
`define MSD_PERIOD_RST      16'h0000
`define MSD_RESULT_RST      16'h0000
`define MSD_UNLOCK_RST      8'h00

// Sizes and timing
`define MSD_PIXEL_COUNT     1536
`define MSD_STEP_SHIFT      4
`define MSD_CLK_MHZ         100
`define MSD_SELFTEST_US     200000
`define MSD_SELFTEST_CYC    (`MSD_SELFTEST_US * `MSD_CLK_MHZ)

`endif

// >>> hdl/msd_pkg.sv
package msd_pkg;

   // One register access from the serial port decoder
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } msd_req_type;

   // Mode bits from the extended configuration register
   typedef struct packed {
      logic auto_gain_disable;
      logic fixed_rate_select;
   } msd_mode_type;

   // Pixel capture sequence
   typedef enum logic [3:0] {
      MSD_CAP_IDLE  = 4'b0001,
      MSD_CAP_WAIT  = 4'b0010,
      MSD_CAP_FILL  = 4'b0100,
      MSD_CAP_READY = 4'b1000
   } msd_cap_state_type;

endpackage

// >>> hdl/msd_crc16.sv
`timescale 1ns/1ps
`include "msd_map.svh"

module msd_crc16 #(
   parameter int DEPTH = `MSD_PIXEL_COUNT,
   parameter int AW    = 11
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rstn,
   // Control
   input  wire logic          start,
   output logic               busy_r,
   output logic               done_r,
   // Memory walk
   output logic [AW-1:0]      addr_r,
   input  wire logic [7:0]    data,
   // Result
   output logic [15:0]        crc_r
);

   // Byte-wise CRC update, MSB first
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  d);
      logic [15:0] v;
      v = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         v = v[15] ? ((v << 1) ^ `MSD_CRC_POLY) : (v << 1);
      end
      return v;
   endfunction

   // Walk the whole memory once per start
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         addr_r <= '0;
         crc_r  <= `MSD_CRC_INIT;
      end else begin
         done_r <= 1'b0;
         if (start && !busy_r) begin
            busy_r <= 1'b1;
            addr_r <= '0;
            crc_r  <= `MSD_CRC_INIT;
         end else if (busy_r) begin
            crc_r <= crc_step(crc_r, data);
            if (addr_r == AW'(DEPTH - 1)) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               addr_r <= addr_r + 1'b1;
            end
         end
      end
   end

endmodule

// >>> hdl/msd_exposure.sv
`timescale 1ns/1ps
`include "msd_map.svh"

module msd_exposure (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Frame events
   input  wire logic        frame_tick,
   input  wire logic        pixels_dark,
   input  wire logic        pixels_bright,
   input  wire logic        restore,
   // Settings
   input  wire logic        auto_gain_disable,
   input  wire logic [15:0] max_bound,
   // Result
   output logic [15:0]      exposure_r
);

   logic [15:0] step;
   logic [16:0] up_sum;

   // One sixteenth of the present value
   assign step   = exposure_r >> `MSD_STEP_SHIFT;
   assign up_sum = {1'b0, exposure_r} + {1'b0, step};

   // Automatic gain loop, once per frame
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         exposure_r <= `MSD_EXPOSE_RST;
      end else if (restore) begin
         exposure_r <= `MSD_EXPOSE_RST;
      end else if (auto_gain_disable) begin
         exposure_r <= max_bound;
      end else if (frame_tick) begin
         if (pixels_dark && !pixels_bright) begin
            if (up_sum > {1'b0, max_bound})
               exposure_r <= max_bound;
            else
               exposure_r <= up_sum[15:0];
         end else if (pixels_bright && !pixels_dark) begin
            // Bound may have been lowered below the present value
            if (exposure_r - step > max_bound)
               exposure_r <= max_bound;
            else
               exposure_r <= exposure_r - step;
         end else if (exposure_r > max_bound) begin
            exposure_r <= max_bound;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   exposure_bound_a: assert property (
      frame_tick && !auto_gain_disable && !restore
      |=> exposure_r <= $past(max_bound))
      else $error("exposure above maximum bound");

   gain_hold_a: assert property (
      auto_gain_disable && !restore |=> exposure_r == $past(max_bound))
      else $error("exposure not held at bound");

endmodule

// >>> hdl/msd_diag_regs.sv
`timescale 1ns/1ps
`include "msd_map.svh"

module msd_diag_regs #(
   parameter int          DEPTH        = `MSD_PIXEL_COUNT,
   parameter int unsigned SELFTEST_CYC = `MSD_SELFTEST_CYC,
   parameter logic [15:0] FW_CRC_GOOD  = 16'h0000
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // Register access from serial port
   input  wire msd_pkg::msd_req_type  req,
   output logic [7:0]                 rd_data_r,
   output logic                       rd_valid_r,
   // Configuration
   input  wire msd_pkg::msd_mode_type mode,
   input  wire logic [15:0]           shutter_max_bound,
   input  wire logic [15:0]           period_max_bound,
   input  wire logic [15:0]           auto_period,
   // Image array
   input  wire logic                  frame_tick,
   input  wire logic                  pixels_dark,
   input  wire logic                  pixels_bright,
   input  wire logic                  pixel_valid,
   input  wire logic [7:0]            pixel_data,
   // Self test
   input  wire logic                  selftest_start,
   input  wire logic                  selftest_fault,
   // Firmware download stream
   input  wire logic                  fw_stream_valid,
   input  wire logic [7:0]            fw_stream_data,
   // Pixel burst
   input  wire logic                  pixel_burst_rd,
   output logic [7:0]                 pixel_burst_data_r,
   // Navigation control
   output logic                       motion_clear_r,
   output logic                       nav_halt_r,
   output logic                       defaults_restore_r,
   output logic                       fw_loaded_r
);

   localparam int AW = 11;

   msd_pkg::msd_cap_state_type cap_state_r;
   logic [7:0]    ram_r [0:DEPTH-1];
   logic [AW-1:0] cap_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW-1:0] fw_ptr_r;
   logic [AW-1:0] crc_addr;
   logic [7:0]    unlock_r;
   logic [15:0]   result_r;
   logic [15:0]   period_r;
   logic [15:0]   exposure;
   logic [15:0]   crc_val;
   logic [7:0]    shadow_r;
   logic [6:0]    shadow_src_r;
   logic          capture_halt_r;
   logic [24:0]   st_cnt_r;
   logic          st_busy_r;
   logic          st_done;
   logic          crc_busy;
   logic          crc_done;
   logic          crc_start;
   logic          wr_capture;
   logic          rd_pixel;
   logic          ptr_step;
   logic          dl_accept;
   logic [7:0]    rd_mux;

   // Access decode
   assign wr_capture = req.wr && (req.addr == `MSD_OFS_PIXEL);
   assign rd_pixel   = req.rd && (req.addr == `MSD_OFS_PIXEL);
   assign crc_start  = req.wr && (req.addr == `MSD_OFS_UNLOCK)
                       && (req.wdata == `MSD_UNLOCK_CRC);
   assign ptr_step   = (cap_state_r == msd_pkg::MSD_CAP_READY)
                       && (rd_pixel || pixel_burst_rd);
   assign dl_accept  = fw_stream_valid
                       && (unlock_r == `MSD_UNLOCK_LOAD)
                       && !capture_halt_r && !crc_busy && !st_busy_r;
   assign st_done    = st_busy_r && (st_cnt_r == 25'h0000000);

   // Unlock value, kept for the download gate
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         unlock_r <= `MSD_UNLOCK_RST;
      else if (defaults_restore_r)
         unlock_r <= `MSD_UNLOCK_RST;
      else if (req.wr && (req.addr == `MSD_OFS_UNLOCK))
         unlock_r <= req.wdata;
   end

   // Firmware memory: capture has priority over download
   always_ff @(posedge clock) begin
      if (cap_state_r == msd_pkg::MSD_CAP_FILL && pixel_valid)
         ram_r[cap_ptr_r] <= pixel_data;
      else if (dl_accept)
         ram_r[fw_ptr_r] <= fw_stream_data;
   end

   // Download pointer and loaded flag
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fw_ptr_r    <= '0;
         fw_loaded_r <= 1'b0;
      end else if (wr_capture || defaults_restore_r) begin
         fw_ptr_r    <= '0;
         fw_loaded_r <= 1'b0;
      end else if (dl_accept) begin
         fw_ptr_r    <= (fw_ptr_r == AW'(DEPTH - 1)) ? '0 : fw_ptr_r + 1'b1;
         fw_loaded_r <= 1'b1;
      end
   end

   // Capture sequence: wait a frame start, then fill
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cap_state_r <= msd_pkg::MSD_CAP_IDLE;
         cap_ptr_r   <= '0;
      end else if (wr_capture) begin
         cap_ptr_r <= '0;
         if (req.wdata == `MSD_CAPTURE_KEY)
            cap_state_r <= msd_pkg::MSD_CAP_WAIT;
         else
            cap_state_r <= msd_pkg::MSD_CAP_IDLE;
      end else begin
         case (cap_state_r)
            msd_pkg::MSD_CAP_IDLE: begin
               cap_state_r <= msd_pkg::MSD_CAP_IDLE;
            end
            msd_pkg::MSD_CAP_WAIT: begin
               if (frame_tick)
                  cap_state_r <= msd_pkg::MSD_CAP_FILL;
            end
            msd_pkg::MSD_CAP_FILL: begin
               if (pixel_valid) begin
                  cap_ptr_r <= cap_ptr_r + 1'b1;
                  if (cap_ptr_r == AW'(DEPTH - 1))
                     cap_state_r <= msd_pkg::MSD_CAP_READY;
               end
            end
            msd_pkg::MSD_CAP_READY: begin
               cap_state_r <= msd_pkg::MSD_CAP_READY;
            end
            default: begin
               cap_state_r <= msd_pkg::MSD_CAP_IDLE;
            end
         endcase
      end
   end

   // Shared readout pointer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         rd_ptr_r <= '0;
      else if (wr_capture)
         rd_ptr_r <= '0;
      else if (ptr_step)
         rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
   end

   // Burst data from the same pointer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         pixel_burst_data_r <= 8'h00;
      else if (pixel_burst_rd)
         pixel_burst_data_r <= (cap_state_r == msd_pkg::MSD_CAP_READY)
                               ? ram_r[rd_ptr_r] : 8'h00;
   end

   // Navigation halt: capture halt sticks until reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         capture_halt_r <= 1'b0;
         nav_halt_r     <= 1'b0;
      end else begin
         if (wr_capture)
            capture_halt_r <= 1'b1;
         nav_halt_r <= capture_halt_r || wr_capture
                       || crc_busy || crc_start || st_busy_r;
      end
   end

   // Self test timer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_busy_r <= 1'b0;
         st_cnt_r  <= '0;
      end else if (selftest_start && !st_busy_r) begin
         st_busy_r <= 1'b1;
         st_cnt_r  <= 25'(SELFTEST_CYC - 1);
      end else if (st_busy_r) begin
         if (st_done)
            st_busy_r <= 1'b0;
         else
            st_cnt_r <= st_cnt_r - 1'b1;
      end
   end

   // Defaults restored after the self test
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         defaults_restore_r <= 1'b0;
      else
         defaults_restore_r <= st_done;
   end

   // Result word: whichever test finished last
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         result_r <= `MSD_RESULT_RST;
      else if (st_done)
         result_r <= selftest_fault ? `MSD_SELFTEST_FAIL
                                    : `MSD_SELFTEST_PASS;
      else if (crc_done)
         result_r <= (crc_val == FW_CRC_GOOD) ? `MSD_CRC_PASS
                                              : crc_val;
   end

   // Frame period readout, refreshed each frame
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         period_r <= `MSD_PERIOD_RST;
      else if (frame_tick)
         period_r <= mode.fixed_rate_select ? period_max_bound
                                            : auto_period;
   end

   // Motion clear strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         motion_clear_r <= 1'b0;
      else
         motion_clear_r <= req.wr && (req.addr == `MSD_OFS_MCLEAR);
   end

   // Upper reads snapshot the lower byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shadow_r     <= 8'h00;
         shadow_src_r <= 7'h00;
      end else if (req.rd) begin
         shadow_src_r <= 7'h00;
         case (req.addr)
            `MSD_OFS_RESULT_HI: begin
               shadow_r     <= result_r[7:0];
               shadow_src_r <= `MSD_OFS_RESULT_LO;
            end
            `MSD_OFS_EXPOSE_HI: begin
               shadow_r     <= exposure[7:0];
               shadow_src_r <= `MSD_OFS_EXPOSE_LO;
            end
            `MSD_OFS_PERIOD_HI: begin
               shadow_r     <= period_r[7:0];
               shadow_src_r <= `MSD_OFS_PERIOD_LO;
            end
            default: begin
               shadow_r <= shadow_r;
            end
         endcase
      end
   end

   // Read data select
   always_comb begin
      case (req.addr)
         `MSD_OFS_RESULT_HI: rd_mux = result_r[15:8];
         `MSD_OFS_EXPOSE_HI: rd_mux = exposure[15:8];
         `MSD_OFS_PERIOD_HI: rd_mux = period_r[15:8];
         `MSD_OFS_RESULT_LO: rd_mux = (shadow_src_r == req.addr)
                                      ? shadow_r : result_r[7:0];
         `MSD_OFS_EXPOSE_LO: rd_mux = (shadow_src_r == req.addr)
                                      ? shadow_r : exposure[7:0];
         `MSD_OFS_PERIOD_LO: rd_mux = (shadow_src_r == req.addr)
                                      ? shadow_r : period_r[7:0];
         `MSD_OFS_PIXEL:     rd_mux = (cap_state_r == msd_pkg::MSD_CAP_READY)
                                      ? ram_r[rd_ptr_r] : 8'h00;
         default:            rd_mux = 8'h00;
      endcase
   end

   // Registered read answer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= req.rd;
         if (req.rd)
            rd_data_r <= rd_mux;
      end
   end

   msd_crc16 #(
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_crc (
      .clock  (clock),
      .rstn   (rstn),
      .start  (crc_start),
      .busy_r (crc_busy),
      .done_r (crc_done),
      .addr_r (crc_addr),
      .data   (ram_r[crc_addr]),
      .crc_r  (crc_val)
   );

   msd_exposure u_exposure (
      .clock             (clock),
      .rstn              (rstn),
      .frame_tick        (frame_tick),
      .pixels_dark       (pixels_dark),
      .pixels_bright     (pixels_bright),
      .restore           (defaults_restore_r),
      .auto_gain_disable (mode.auto_gain_disable),
      .max_bound         (shutter_max_bound),
      .exposure_r        (exposure)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence cap_write_s;
      wr_capture;
   endsequence
   sequence halt_held_s;
      nav_halt_r [*4];
   endsequence

   selftest_pass_a: assert property (
      st_done && !selftest_fault |=> result_r == `MSD_SELFTEST_PASS)
      else $error("self test pass word wrong");
   crc_pass_a: assert property (
      crc_done && !st_done && crc_val == FW_CRC_GOOD
      |=> result_r == `MSD_CRC_PASS)
      else $error("crc pass word wrong");
   motion_clear_a: assert property (
      req.wr && req.addr == `MSD_OFS_MCLEAR |=> motion_clear_r)
      else $error("motion clear strobe missing");
   capture_halt_a: assert property (
      cap_write_s |=> halt_held_s)
      else $error("navigation not halted after capture write");
   early_read_a: assert property (
      rd_pixel && cap_state_r != msd_pkg::MSD_CAP_READY
      |=> rd_valid_r && rd_data_r == 8'h00)
      else $error("early pixel read not zero");
   load_reject_a: assert property (
      fw_stream_valid && unlock_r != `MSD_UNLOCK_LOAD && !wr_capture
      && !defaults_restore_r |=> $stable(fw_ptr_r))
      else $error("download taken while locked");
   crc_halt_a: assert property (
      crc_start && !crc_busy |=> nav_halt_r ##1 nav_halt_r)
      else $error("navigation running during crc");
   pointer_step_a: assert property (
      rd_pixel && cap_state_r == msd_pkg::MSD_CAP_READY
      && rd_ptr_r != AW'(DEPTH - 1)
      |=> rd_ptr_r == $past(rd_ptr_r) + 1'b1)
      else $error("pixel pointer did not advance");

endmodule

// >>> verification/msd_host_model.sv
`timescale 1ns/1ps
// Serial port master: one register access at a time
module msd_host_model (
   // Clock
   input  wire logic            clock,
   // Register port
   output msd_pkg::msd_req_type req,
   input  wire logic [7:0]      rd_data_r,
   input  wire logic            rd_valid_r
);
   // Idle request from time zero
   initial req = '0;

   // Write: one-cycle strobe, no answer comes back
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clock);
      req.wr <= 1'b0;
      // Let an edge pass so the next call does not reassign req
      @(posedge clock);
   endtask

   // Read: strobe for one edge, take data at the valid edge
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clock);
      req.rd <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (rd_valid_r !== 1'b1 && n < 4);
      d = rd_data_r;
      // A missing answer ends the run
      if (rd_valid_r !== 1'b1) begin
         tb.fail_count++;
         tb.print_verdict();
      end
   endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "msd_map.svh"
module tb;
   logic                 clock;
   logic                 rstn;
   msd_pkg::msd_req_type req;
   logic [7:0]           rd_data_r;
   logic                 rd_valid_r;
   msd_pkg::msd_mode_type mode;
   logic [15:0]          shutter_max_bound;
   logic [15:0]          period_max_bound;
   logic [15:0]          auto_period;
   logic                 frame_tick;
   logic                 pixels_dark;
   logic                 pixels_bright;
   logic                 pixel_valid;
   logic [7:0]           pixel_data;
   logic                 selftest_start;
   logic                 selftest_fault;
   logic                 fw_stream_valid;
   logic [7:0]           fw_stream_data;
   logic                 pixel_burst_rd;
   logic [7:0]           pixel_burst_data_r;
   logic                 motion_clear_r;
   logic                 nav_halt_r;
   logic                 defaults_restore_r;
   logic                 fw_loaded_r;
   int                   fail_count = 0;
   int                   cmp_count = 0;
   logic [7:0]           b;
   int                   n;

   // Byte pattern for firmware image and pixels
   function automatic logic [7:0] pix(input int i);
      return i[7:0] ^ 8'h5A;
   endfunction

   // CRC of the image, MSB first
   function automatic logic [15:0] crc_img();
      logic [15:0] c;
      logic [7:0]  d;
      c = `MSD_CRC_INIT;
      for (int i = 0; i < 1536; i++) begin
         for (int k = 7; k >= 0; k--) begin
            d = pix(i);
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `MSD_CRC_POLY : 16'h0);
         end
      end
      return c;
   endfunction

   msd_diag_regs #(.SELFTEST_CYC(16), .FW_CRC_GOOD(crc_img())) dut_u (
      .clock(clock), .rstn(rstn), .req(req), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r), .mode(mode),
      .shutter_max_bound(shutter_max_bound),
      .period_max_bound(period_max_bound), .auto_period(auto_period),
      .frame_tick(frame_tick), .pixels_dark(pixels_dark),
      .pixels_bright(pixels_bright), .pixel_valid(pixel_valid),
      .pixel_data(pixel_data), .selftest_start(selftest_start),
      .selftest_fault(selftest_fault), .fw_stream_valid(fw_stream_valid),
      .fw_stream_data(fw_stream_data), .pixel_burst_rd(pixel_burst_rd),
      .pixel_burst_data_r(pixel_burst_data_r),
      .motion_clear_r(motion_clear_r), .nav_halt_r(nav_halt_r),
      .defaults_restore_r(defaults_restore_r), .fw_loaded_r(fw_loaded_r));

   msd_host_model host_u (
      .clock(clock), .req(req), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r));

   // Free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic print_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Upper then lower read of a pair, compared as one word
   task automatic chk16(input logic [6:0] hi, input logic [15:0] e);
      logic [7:0] h;
      logic [7:0] l;
      host_u.rd(hi, h);
      host_u.rd(hi - 7'h01, l);
      chk({h, l}, e);
   endtask

   task automatic chk8(input logic [6:0] a, input logic [7:0] e);
      host_u.rd(a, b);
      chk({8'h00, b}, {8'h00, e});
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
   endtask

   task automatic tick(input logic dark, input logic bright);
      pixels_dark <= dark;
      pixels_bright <= bright;
      frame_tick <= 1'b1;
      @(posedge clock);
      frame_tick <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   // Byte stream to the firmware port or the pixel port
   task automatic stream(input logic fw, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         fw_stream_valid <= fw;
         pixel_valid <= ~fw;
         fw_stream_data <= pix(i);
         pixel_data <= ~pix(i);
         @(posedge clock);
         fw_stream_valid <= 1'b0;
         pixel_valid <= 1'b0;
         @(posedge clock);
      end
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      mode = '0;
      shutter_max_bound = 16'hFFFF;
      period_max_bound = 16'h2EE0;
      auto_period = 16'h1234;
      {frame_tick, pixels_dark, pixels_bright, pixel_valid} = 4'h0;
      {selftest_start, selftest_fault, fw_stream_valid} = 3'h0;
      {pixel_data, fw_stream_data, pixel_burst_rd} = 17'h00000;
      do_reset();
      // Reset values, write-only and unmapped reads
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0085);
      chk16(`MSD_OFS_PERIOD_HI, 16'h0000);
      chk8(`MSD_OFS_MCLEAR, 8'h00);
      chk8(`MSD_OFS_UNLOCK, 8'h00);
      chk8(7'h15, 8'h00);
      chk8(`MSD_OFS_PIXEL, 8'h00);
      host_u.wr(`MSD_OFS_EXPOSE_LO, 8'h55);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0085);
      // Exposure steps, clamp and manual hold
      tick(1'b1, 1'b0);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h008D);
      tick(1'b0, 1'b1);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0085);
      shutter_max_bound <= 16'h0088;
      tick(1'b1, 1'b0);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0088);
      shutter_max_bound <= 16'h0123;
      mode.auto_gain_disable <= 1'b1;
      tick(1'b1, 1'b0);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0123);
      mode.auto_gain_disable <= 1'b0;
      shutter_max_bound <= 16'hFFFF;
      // Frame period, snapshot coherence, fixed rate
      tick(1'b0, 1'b0);
      chk16(`MSD_OFS_PERIOD_HI, 16'h1234);
      host_u.rd(`MSD_OFS_PERIOD_HI, b);
      auto_period <= 16'h5678;
      tick(1'b0, 1'b0);
      chk8(`MSD_OFS_PERIOD_LO, 8'h34);
      chk16(`MSD_OFS_PERIOD_HI, 16'h5678);
      mode.fixed_rate_select <= 1'b1;
      tick(1'b0, 1'b0);
      chk16(`MSD_OFS_PERIOD_HI, 16'h2EE0);
      // Motion clear strobe
      host_u.wr(`MSD_OFS_MCLEAR, 8'hA5);
      for (n = 0; n < 3 && motion_clear_r !== 1'b1; n++) @(posedge clock);
      chk({15'h0, motion_clear_r}, 16'h0001);
      // Locked bytes refused, unlocked image checked by CRC test
      stream(1'b1, 4);
      chk({15'h0, fw_loaded_r}, 16'h0000);
      host_u.wr(`MSD_OFS_UNLOCK, `MSD_UNLOCK_LOAD);
      stream(1'b1, 1536);
      chk({15'h0, fw_loaded_r}, 16'h0001);
      host_u.wr(`MSD_OFS_UNLOCK, `MSD_UNLOCK_CRC);
      repeat (2) @(posedge clock);
      chk({15'h0, nav_halt_r}, 16'h0001);
      repeat (1600) @(posedge clock);
      chk16(`MSD_OFS_RESULT_HI, `MSD_CRC_PASS);
      // Self test after a fresh reset restores defaults
      do_reset();
      tick(1'b1, 1'b0);
      selftest_start <= 1'b1;
      @(posedge clock);
      selftest_start <= 1'b0;
      for (n = 0; n < 40 && defaults_restore_r !== 1'b1; n++)
         @(posedge clock);
      chk({15'h0, defaults_restore_r}, 16'h0001);
      chk16(`MSD_OFS_RESULT_HI, `MSD_SELFTEST_PASS);
      chk16(`MSD_OFS_EXPOSE_HI, 16'h0085);
      // Capture arm, fill, shared pointer readout
      host_u.wr(`MSD_OFS_PIXEL, `MSD_CAPTURE_KEY);
      @(posedge clock);
      chk({14'h0, nav_halt_r, fw_loaded_r}, 16'h0002);
      chk8(`MSD_OFS_PIXEL, 8'h00);
      tick(1'b0, 1'b0);
      stream(1'b0, 1536);
      chk8(`MSD_OFS_PIXEL, ~pix(0));
      chk8(`MSD_OFS_PIXEL, ~pix(1));
      pixel_burst_rd <= 1'b1;
      @(posedge clock);
      pixel_burst_rd <= 1'b0;
      @(posedge clock);
      chk({8'h00, pixel_burst_data_r}, {8'h00, ~pix(2)});
      for (int i = 3; i < 1537; i++)
         chk8(`MSD_OFS_PIXEL, ~pix(i % 1536));
      print_verdict();
   end
endmodule
